//--- common/dcl_pkg.sv
// Constants and types shared by the default configuration loader
// How it works
// - Strap low at load: functional defaults come from the fuse mirror registers.
// - Strap at internal 1.5 V rail: every reload uses the built-in table.
// - Fuse sourcing: copy fuses into mirrors on each rising undervoltage crossing.
// - Second stage copies mirror contents into the functional registers.
// - Built-in source selected: trial configuration mode is never entered.
// - Trim or self-test failure, or fuse failure with fuse source, sets its flag and blocks power-up until cleared.
// - Fault flags clear only while trial enable pin is high; otherwise read only, except that built-in source zeroes the fuse flag.
// - Trial mode ignores low-power-off default and forces the quiet powered-off state.
// - Trial mode reports real self-test result in its flag, 0 pass, 1 fail.
// - Trial mode: no CRC, no secure write, target address 0x08.
// - Trial mode disables external watchdog input and internal watchdog timer.
// - Three-bit page select; in trial mode mirrors appear in extended page 1.
// - Trial enable pin low: every extended page access is refused.
// - Mirrors hold fused values; host may rewrite them in trial mode.
// - Power-up with trial pin high gives limited functions; low gives full.
// - Trial setup holds while supply stays up; supply loss resets the mirrors.
package dcl_pkg;
    localparam int          DCL_WORDS        = 18;
    localparam int          DCL_IDX_W        = 5;
    localparam logic [4:0]  DCL_LAST_IDX     = 5'h11;
    localparam logic [7:0]  DCL_PAGE_ADDR    = 8'h77;
    localparam logic [7:0]  DCL_FLAGS_ADDR   = 8'h7A;
    localparam logic [7:0]  DCL_MIRROR_BASE  = 8'hA0;
    localparam logic [7:0]  DCL_MIRROR_END   = 8'hB1;
    localparam logic [2:0]  DCL_PAGE_RESET   = 3'h0;
    localparam logic [2:0]  DCL_PAGE_MIRROR  = 3'h1;
    localparam logic [2:0]  DCL_FLAGS_RESET  = 3'h0;
    localparam logic [6:0]  DCL_TRIAL_ADDR   = 7'h08;
    localparam int          DCL_TRIM_BIT     = 0;
    localparam int          DCL_FUSE_BIT     = 1;
    localparam int          DCL_STEST_BIT    = 2;
    localparam logic [4:0]  DCL_PAD5         = 5'h00;
    localparam logic [7:0]  DCL_ZERO8        = 8'h00;

    // Built-in configuration, element 0 is the last word listed
    localparam logic [DCL_WORDS-1:0][7:0] DCL_HARDWIRE = {
        8'h01, 8'h60, 8'h00, 8'h07, 8'h02, 8'h01, 8'h00, 8'h0F, 8'hFF,
        8'hAF, 8'h07, 8'h10, 8'h00, 8'h00, 8'h01, 8'h05, 8'h02, 8'h00};

    typedef enum logic [1:0] {DCL_IDLE, DCL_FUSE, DCL_FUNC} dcl_load_type;

    typedef struct packed {
        dcl_load_type                ld;
        logic [DCL_IDX_W-1:0]        idx;
        logic [DCL_WORDS-1:0][7:0]   mirror;
        logic [2:0]                  page;
        logic [2:0]                  flags;
        logic [7:0]                  rdata;
        logic                        rerr;
        logic                        func_we;
        logic [DCL_IDX_W-1:0]        func_addr;
        logic [7:0]                  func_data;
        logic                        load_done;
        logic                        pu_go;
        logic                        pu_limited;
        logic                        trial;
        logic [6:0]                  i2c_addr;
        logic                        crc_en;
        logic                        sec_en;
        logic                        wd_en;
    } dcl_state_type;
endpackage

//--- rtl/dcl_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module dcl_pin_sync (
    input  wire logic core_clk_in,
    input  wire logic rst_n_in,
    input  wire logic pin_in,
    output logic      level_out
);
    logic meta_r;
    logic s2_r;
    logic s3_r;

    // First stage feeds only the second; change accepted once two and three agree
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_r    <= 1'b0;
            s2_r      <= 1'b0;
            s3_r      <= 1'b0;
            level_out <= 1'b0;
        end else begin
            meta_r <= pin_in;
            s2_r   <= meta_r;
            s3_r   <= s2_r;
            if (s2_r == s3_r) begin
                level_out <= s3_r;
            end
        end
    end
endmodule // dcl_pin_sync

//--- rtl/dcl_loader.sv
// Default configuration loader: source select, mirror load, trial mode, fault flags
`timescale 1ns/10ps
module dcl_loader
    import dcl_pkg::*;
(
    input  wire logic                 core_clk_in,
    input  wire logic                 rst_n_in,
    input  wire logic                 config_source_strap_pin_in,
    input  wire logic                 trial_config_enable_pin_in,
    input  wire logic                 uv_rise_in,
    input  wire logic                 main_input_supply_low_in,
    input  wire logic                 reload_req_in,
    input  wire logic                 trim_done_in,
    input  wire logic                 trim_ok_in,
    input  wire logic                 fuse_done_in,
    input  wire logic                 fuse_ok_in,
    input  wire logic                 stest_done_in,
    input  wire logic                 stest_ok_in,
    input  wire logic [7:0]           fuse_rd_data_in,
    output logic [DCL_IDX_W-1:0]      fuse_rd_addr_out,
    input  wire logic                 reg_wr_in,
    input  wire logic                 reg_rd_in,
    input  wire logic [7:0]           reg_addr_in,
    input  wire logic [7:0]           reg_wdata_in,
    output logic [7:0]                reg_rdata_out,
    output logic                      reg_err_out,
    input  wire logic                 quiet_powered_off_state_in,
    input  wire logic                 power_up_event_in,
    output logic                      power_up_go_out,
    output logic                      power_up_limited_out,
    output logic                      func_wr_en_out,
    output logic [DCL_IDX_W-1:0]      func_wr_addr_out,
    output logic [7:0]                func_wr_data_out,
    output logic                      load_done_out,
    input  wire logic [6:0]           cfg_i2c_addr_in,
    input  wire logic                 cfg_crc_en_in,
    input  wire logic                 cfg_secure_en_in,
    input  wire logic                 cfg_wd_en_in,
    output logic [6:0]                i2c_target_addr_out,
    output logic                      i2c_crc_en_out,
    output logic                      i2c_secure_en_out,
    output logic                      watchdog_enable_out,
    output logic                      trial_config_mode_out,
    output logic                      force_quiet_off_out,
    output logic [2:0]                fault_flags_out
);
    dcl_state_type s_r;
    dcl_state_type s_nxt;
    logic          strap_s;
    logic          tpin_s;
    logic          in_window;
    logic [7:0]    woff;
    logic          ext_ok;
    logic          flag_clr;

    // Both straps are pins from outside the clock domain
    dcl_pin_sync u_strap_sync (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .pin_in      (config_source_strap_pin_in),
        .level_out   (strap_s)
    );

    dcl_pin_sync u_trial_sync (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .pin_in      (trial_config_enable_pin_in),
        .level_out   (tpin_s)
    );

    // Register decode helpers
    assign in_window = (reg_addr_in >= DCL_MIRROR_BASE) && (reg_addr_in <= DCL_MIRROR_END);
    assign woff      = reg_addr_in - DCL_MIRROR_BASE;
    assign ext_ok    = s_r.trial && (s_r.page == DCL_PAGE_MIRROR);
    // gated clear; keyed to the trial pin, so built-in source with pin high may clear
    assign flag_clr  = reg_wr_in && (reg_addr_in == DCL_FLAGS_ADDR) && tpin_s
                       && quiet_powered_off_state_in;

    // Next-state logic for the whole block
    always_comb begin
        s_nxt         = s_r;
        s_nxt.func_we = 1'b0;
        s_nxt.pu_go   = 1'b0;
        s_nxt.rerr    = 1'b0;

        // no trial on built-in source; pin high enters trial mode
        s_nxt.trial = tpin_s && !strap_s;
        s_nxt.i2c_addr = s_nxt.trial ? DCL_TRIAL_ADDR : cfg_i2c_addr_in;
        s_nxt.crc_en   = cfg_crc_en_in && !s_nxt.trial;
        s_nxt.sec_en   = cfg_secure_en_in && !s_nxt.trial;
        s_nxt.wd_en    = cfg_wd_en_in && !s_nxt.trial;
        if (!s_nxt.trial) begin
            s_nxt.page = DCL_PAGE_RESET;
        end

        // Load sequencer
        unique case (s_r.ld)
            DCL_IDLE: begin
                if (uv_rise_in && !main_input_supply_low_in) begin
                    s_nxt.idx       = '0;
                    s_nxt.load_done = 1'b0;
                    // fuse stage on rising crossing; built-in skips it
                    s_nxt.ld = strap_s ? DCL_FUNC : DCL_FUSE;
                end else if (reload_req_in) begin
                    s_nxt.idx       = '0;
                    s_nxt.load_done = 1'b0;
                    s_nxt.ld        = DCL_FUNC;
                end
            end
            DCL_FUSE: begin
                s_nxt.mirror[s_r.idx] = fuse_rd_data_in;
                s_nxt.idx = s_r.idx + 5'h01;
                if (s_r.idx == DCL_LAST_IDX) begin
                    s_nxt.idx = '0;
                    s_nxt.ld  = DCL_FUNC;
                end
            end
            DCL_FUNC: begin
                s_nxt.func_we   = 1'b1;
                s_nxt.func_addr = s_r.idx;
                s_nxt.func_data = strap_s ? DCL_HARDWIRE[s_r.idx] : s_r.mirror[s_r.idx];
                s_nxt.idx = s_r.idx + 5'h01;
                if (s_r.idx == DCL_LAST_IDX) begin
                    s_nxt.idx       = '0;
                    s_nxt.ld        = DCL_IDLE;
                    s_nxt.load_done = 1'b1;
                end
            end
            // Unused code after an upset falls back to idle
            default: begin
                s_nxt.ld = DCL_IDLE;
            end
        endcase

        // Register reads answer next cycle
        s_nxt.rdata = DCL_ZERO8;
        if (reg_rd_in) begin
            if (reg_addr_in == DCL_PAGE_ADDR) begin
                s_nxt.rdata = {DCL_PAD5, s_r.page};
            end else if (reg_addr_in == DCL_FLAGS_ADDR) begin
                s_nxt.rdata = {DCL_PAD5, s_r.flags};
            end else if (in_window) begin
                if (ext_ok) begin
                    s_nxt.rdata = s_r.mirror[woff[DCL_IDX_W-1:0]];
                end else begin
                    s_nxt.rerr = 1'b1;
                end
            end
        end

        // Register writes
        if (reg_wr_in) begin
            if (reg_addr_in == DCL_PAGE_ADDR) begin
                // Selector is writable only in trial mode
                if (s_r.trial) begin
                    s_nxt.page = reg_wdata_in[2:0];
                end else begin
                    s_nxt.rerr = 1'b1;
                end
            end else if (reg_addr_in == DCL_FLAGS_ADDR) begin
                s_nxt.rerr = !flag_clr;
            end else if (in_window) begin
                // host rewrite in trial; refuse otherwise
                if (ext_ok && s_r.ld == DCL_IDLE) begin
                    s_nxt.mirror[woff[DCL_IDX_W-1:0]] = reg_wdata_in;
                end else begin
                    s_nxt.rerr = 1'b1;
                end
            end
        end

        // write 1 clears, set below wins
        if (flag_clr) begin
            s_nxt.flags = s_r.flags & ~reg_wdata_in[2:0];
        end
        if (trim_done_in && !trim_ok_in) begin
            s_nxt.flags[DCL_TRIM_BIT] = 1'b1;
        end
        // Built-in source keeps the fuse flag at zero
        if (strap_s) begin
            s_nxt.flags[DCL_FUSE_BIT] = 1'b0;
        end else if (fuse_done_in && !fuse_ok_in) begin
            s_nxt.flags[DCL_FUSE_BIT] = 1'b1;
        end
        if (stest_done_in) begin
            // trial reports the real outcome both ways
            if (s_r.trial) begin
                s_nxt.flags[DCL_STEST_BIT] = !stest_ok_in;
            end else if (!stest_ok_in) begin
                s_nxt.flags[DCL_STEST_BIT] = 1'b1;
            end
        end

        if (power_up_event_in && s_r.flags == DCL_FLAGS_RESET && s_r.ld == DCL_IDLE) begin
            s_nxt.pu_go = 1'b1;
            // limited functions when trial pin high
            s_nxt.pu_limited = tpin_s;
        end

        // supply loss wipes the mirrors and aborts a load
        if (main_input_supply_low_in) begin
            s_nxt.mirror    = '0;
            s_nxt.ld        = DCL_IDLE;
            s_nxt.idx       = '0;
            s_nxt.load_done = 1'b0;
        end
    end

    // State register; everything resets to constants
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_r       <= '0;
            s_r.ld    <= DCL_IDLE;
            s_r.page  <= DCL_PAGE_RESET;
            s_r.flags <= DCL_FLAGS_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign fuse_rd_addr_out      = s_r.idx;
    assign reg_rdata_out         = s_r.rdata;
    assign reg_err_out           = s_r.rerr;
    assign power_up_go_out       = s_r.pu_go;
    assign power_up_limited_out  = s_r.pu_limited;
    assign func_wr_en_out        = s_r.func_we;
    assign func_wr_addr_out      = s_r.func_addr;
    assign func_wr_data_out      = s_r.func_data;
    assign load_done_out         = s_r.load_done;
    assign i2c_target_addr_out   = s_r.i2c_addr;
    assign i2c_crc_en_out        = s_r.crc_en;
    assign i2c_secure_en_out     = s_r.sec_en;
    assign watchdog_enable_out   = s_r.wd_en;
    assign trial_config_mode_out = s_r.trial;
    // trial forces quiet powered-off regardless of self-test
    assign force_quiet_off_out   = s_r.trial;
    assign fault_flags_out       = s_r.flags;

    // Checks on the loader behaviour
    default clocking dcl_cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence dcl_fuse_last;
        s_r.ld == DCL_FUSE && s_r.idx == DCL_LAST_IDX && !main_input_supply_low_in;
    endsequence

    sequence dcl_func_first;
        s_r.ld == DCL_FUNC && s_r.idx == 5'h00;
    endsequence

    a_builtin_no_trial: assert property (strap_s |=> !s_r.trial)
        else $error("trial mode with built-in source");
    a_fuse_stage_start: assert property (s_r.ld == DCL_IDLE && uv_rise_in && !strap_s
        && !main_input_supply_low_in |=> s_r.ld == DCL_FUSE && s_r.idx == 5'h00)
        else $error("fuse stage did not start");
    a_builtin_reload: assert property (s_r.ld == DCL_IDLE && uv_rise_in && strap_s
        && !main_input_supply_low_in |=> dcl_func_first)
        else $error("built-in reload did not start");
    a_stage_two_follows: assert property (dcl_fuse_last |=> dcl_func_first)
        else $error("second stage missing");
    a_mirror_source: assert property (s_r.ld == DCL_FUNC && !strap_s
        && !main_input_supply_low_in |=> func_wr_en_out
        && func_wr_data_out == $past(s_r.mirror[s_r.idx]))
        else $error("functional data not from mirror");
    a_powerup_blocked: assert property (power_up_event_in && s_r.flags != DCL_FLAGS_RESET
        |=> !power_up_go_out)
        else $error("power-up passed with fault flag");
    // Built-in source zeroes the fuse bit on its own, so that bit is exempt then
    a_flags_read_only: assert property (!tpin_s
        |=> (s_r.flags & $past(s_r.flags))
            == ($past(s_r.flags) & ~{1'b0, $past(strap_s), 1'b0}))
        else $error("flag cleared with trial pin low");
    a_stest_reported: assert property (s_r.trial && stest_done_in
        |=> s_r.flags[DCL_STEST_BIT] == !$past(stest_ok_in))
        else $error("self-test flag wrong in trial mode");
    a_trial_i2c_addr: assert property (s_r.trial |-> i2c_target_addr_out == DCL_TRIAL_ADDR
        && !i2c_crc_en_out && !i2c_secure_en_out)
        else $error("trial I2C settings wrong");
    a_trial_wd_off: assert property (s_r.trial |-> !watchdog_enable_out)
        else $error("watchdog active in trial mode");
    a_ext_refused: assert property (reg_rd_in && in_window && !s_r.trial |=> reg_err_out)
        else $error("extended access not refused");
    a_mirror_wiped: assert property (main_input_supply_low_in |=> s_r.mirror == '0)
        else $error("mirrors kept after supply loss");
endmodule // dcl_loader

//--- test/dcl_fuse_model.sv
// Fuse memory model feeding the loader's fuse read port
`timescale 1ns/10ps
module dcl_fuse_model
    import dcl_pkg::*;
(
    input  wire logic [DCL_IDX_W-1:0] addr_in,
    output logic [7:0]                data_out
);
    // values seen as mirror preload
    // Pattern differs per word so a skipped or swapped index shows up
    assign data_out = 8'hC3 ^ {3'h0, addr_in};
endmodule // dcl_fuse_model

//--- test/tb.sv
// Self-checking bench for the default configuration loader
`timescale 1ns/10ps
module tb;
    import dcl_pkg::*;
    logic                 core_clk_in, rst_n_in, config_source_strap_pin_in;
    logic                 trial_config_enable_pin_in, uv_rise_in, main_input_supply_low_in;
    logic                 reload_req_in, trim_done_in, trim_ok_in, fuse_done_in, fuse_ok_in;
    logic                 stest_done_in, stest_ok_in, reg_wr_in, reg_rd_in, power_up_event_in;
    logic                 quiet_powered_off_state_in, cfg_crc_en_in, cfg_secure_en_in;
    logic                 cfg_wd_en_in, reg_err_out, power_up_go_out, power_up_limited_out;
    logic                 func_wr_en_out, load_done_out, i2c_crc_en_out, i2c_secure_en_out;
    logic                 watchdog_enable_out, trial_config_mode_out, force_quiet_off_out;
    logic [7:0]           fuse_rd_data_in, reg_addr_in, reg_wdata_in, reg_rdata_out;
    logic [7:0]           func_wr_data_out, rd;
    logic [DCL_IDX_W-1:0] fuse_rd_addr_out, func_wr_addr_out;
    logic [6:0]           cfg_i2c_addr_in, i2c_target_addr_out;
    logic [2:0]           fault_flags_out;
    logic                 er;
    int                   num_errors, checks;

    dcl_loader dut_u (.*);
    dcl_fuse_model fuse_u (.addr_in(fuse_rd_addr_out), .data_out(fuse_rd_data_in));

    // Free-running core clock
    initial begin
        core_clk_in = 1'b0;
        forever #12.5 core_clk_in = ~core_clk_in;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks=%0d errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask

    // One register access; answer sampled one cycle after the strobe
    task automatic reg_op(input logic wr, input logic [7:0] a, input logic [7:0] d);
        reg_wr_in = wr;
        reg_rd_in = ~wr;
        reg_addr_in = a;
        reg_wdata_in = d;
        @(negedge core_clk_in);
        rd = reg_rdata_out;
        er = reg_err_out;
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        @(negedge core_clk_in);
    endtask

    // Result strobes, bit order self-test, fuse, trim
    task automatic strobe(input logic [2:0] done, input logic [2:0] ok);
        {stest_done_in, fuse_done_in, trim_done_in} = done;
        {stest_ok_in, fuse_ok_in, trim_ok_in} = ok;
        @(negedge core_clk_in);
        {stest_done_in, fuse_done_in, trim_done_in} = 3'h0;
        @(negedge core_clk_in);
    endtask

    // Power-up request; go pulse sampled in the following cycle
    task automatic pu_event(input logic go, input logic lim);
        power_up_event_in = 1'b1;
        @(negedge core_clk_in);
        power_up_event_in = 1'b0;
        check({7'h0, power_up_go_out}, {7'h0, go});
        @(negedge core_clk_in);
        check({7'h0, power_up_limited_out}, {7'h0, lim});
    endtask

    // Collect functional writes after a trigger raised by the caller
    task automatic run_load(input logic hw);
        int n;
        n = 0;
        for (int i = 0; i < 60; i++) begin
            @(negedge core_clk_in);
            uv_rise_in = 1'b0;
            reload_req_in = 1'b0;
            if (func_wr_en_out === 1'b1) begin
                check({3'h0, func_wr_addr_out}, n[7:0]);
                check(func_wr_data_out, hw ? DCL_HARDWIRE[n] : (8'hC3 ^ n[7:0]));
                n++;
            end
        end
        if (n != 18) begin
            num_errors++;
            test_done();
        end
        check({7'h0, load_done_out}, 8'h01);
    endtask

    task automatic s_fuse_load();
        reg_op(1'b0, DCL_PAGE_ADDR, 8'h00);
        check(rd, 8'h00);
        uv_rise_in = 1'b1;
        run_load(1'b0);
        check({1'h0, i2c_target_addr_out}, {1'h0, cfg_i2c_addr_in});
        check({5'h0, i2c_crc_en_out, i2c_secure_en_out, watchdog_enable_out}, 8'h07);
        reg_op(1'b0, 8'hA2, 8'h00);
        check({7'h0, er}, 8'h01);
        check(rd, 8'h00);
        reg_op(1'b1, DCL_PAGE_ADDR, 8'h01);
        check({7'h0, er}, 8'h01);
    endtask

    task automatic s_trial();
        // system pulls the trial pin to the rail
        trial_config_enable_pin_in = 1'b1;
        cyc(6);
        check({6'h0, trial_config_mode_out, force_quiet_off_out}, 8'h03);
        check({1'h0, i2c_target_addr_out}, {1'h0, DCL_TRIAL_ADDR});
        check({5'h0, i2c_crc_en_out, i2c_secure_en_out, watchdog_enable_out}, 8'h00);
        reg_op(1'b1, DCL_PAGE_ADDR, 8'h01);
        reg_op(1'b0, DCL_PAGE_ADDR, 8'h00);
        check(rd, 8'h01);
        reg_op(1'b0, 8'hB1, 8'h00);
        check(rd, 8'hD2);
        reg_op(1'b1, 8'hA2, 8'h3C);
        check({7'h0, er}, 8'h00);
        reg_op(1'b0, 8'hA2, 8'h00);
        check(rd, 8'h3C);
        // Supply drop wipes the trial setup
        main_input_supply_low_in = 1'b1;
        cyc(1);
        main_input_supply_low_in = 1'b0;
        cyc(1);
        reg_op(1'b0, 8'hA2, 8'h00);
        check(rd, 8'h00);
        trial_config_enable_pin_in = 1'b0;
        cyc(6);
        reg_op(1'b0, 8'hA0, 8'h00);
        check({7'h0, er}, 8'h01);
    endtask

    task automatic s_faults();
        quiet_powered_off_state_in = 1'b1;
        strobe(3'h7, 3'h0);
        check({5'h0, fault_flags_out}, 8'h07);
        pu_event(1'b0, 1'b0);
        reg_op(1'b1, DCL_FLAGS_ADDR, 8'h07);
        check({7'h0, er}, 8'h01);
        check({5'h0, fault_flags_out}, 8'h07);
        trial_config_enable_pin_in = 1'b1;
        cyc(6);
        reg_op(1'b1, DCL_FLAGS_ADDR, 8'h03);
        reg_op(1'b0, DCL_FLAGS_ADDR, 8'h00);
        check(rd, 8'h04);
        strobe(3'h4, 3'h4);
        check({5'h0, fault_flags_out}, 8'h00);
        strobe(3'h4, 3'h0);
        check({5'h0, fault_flags_out}, 8'h04);
        reg_op(1'b1, DCL_FLAGS_ADDR, 8'h04);
        check({5'h0, fault_flags_out}, 8'h00);
        pu_event(1'b1, 1'b1);
        trial_config_enable_pin_in = 1'b0;
        cyc(6);
        pu_event(1'b1, 1'b0);
    endtask

    task automatic s_hardwire();
        config_source_strap_pin_in = 1'b1;
        trial_config_enable_pin_in = 1'b1;
        cyc(6);
        check({6'h0, trial_config_mode_out, force_quiet_off_out}, 8'h00);
        reg_op(1'b1, DCL_PAGE_ADDR, 8'h01);
        check({7'h0, er}, 8'h01);
        reload_req_in = 1'b1;
        run_load(1'b1);
        strobe(3'h2, 3'h0);
        check({5'h0, fault_flags_out}, 8'h00);
        // Trim failure still flags with built-in source
        strobe(3'h1, 3'h0);
        check({5'h0, fault_flags_out}, 8'h01);
        // Trial pin at the rail allows the clear even without trial mode
        reg_op(1'b1, DCL_FLAGS_ADDR, 8'h01);
        check({7'h0, er}, 8'h00);
        check({5'h0, fault_flags_out}, 8'h00);
        // Supply rise reloads straight from the built-in table
        uv_rise_in = 1'b1;
        run_load(1'b1);
    endtask

    // Main sequence: reset, then scenarios, then verdict
    initial begin
        {rst_n_in, config_source_strap_pin_in, trial_config_enable_pin_in} = 3'h0;
        {uv_rise_in, main_input_supply_low_in, reload_req_in, power_up_event_in} = 4'h0;
        {trim_done_in, trim_ok_in, fuse_done_in, fuse_ok_in} = 4'h0;
        {stest_done_in, stest_ok_in, reg_wr_in, reg_rd_in} = 4'h0;
        {quiet_powered_off_state_in, cfg_crc_en_in, cfg_secure_en_in, cfg_wd_en_in} = 4'h7;
        cfg_i2c_addr_in = 7'h2D;
        reg_addr_in = 8'h00;
        reg_wdata_in = 8'h00;
        num_errors = 0;
        checks = 0;
        cyc(3);
        rst_n_in = 1'b1;
        cyc(6);
        s_fuse_load();
        s_trial();
        s_faults();
        s_hardwire();
        test_done();
    end
endmodule // tb
